/* File: test_touch_output_mode_logic.sv */
// Self-checking bench for the touch output stage
`timescale 1ns/1ps
module test_touch_output_mode_logic
   import tom_pkg::*;
;
   localparam int TS  = 200;
   localparam int TL  = 400;
   localparam int HB  = 20;
   localparam int GAP = 30;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        strap_a = 1'b1;
   logic        strap_b = 1'b1;
   logic        gain = 1'b1;
   logic        swap = 1'b0;
   logic        burst_v = 1'b0;
   tom_burst_s  burst = '0;
   logic        so, oe_n, recal, pin;
   logic [15:0] pcnt;
   logic [3:0]  awaddr = 4'h0;
   logic [3:0]  araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        awv = 1'b0;
   logic        wv = 1'b0;
   logic        bready = 1'b0;
   logic        arv = 1'b0;
   logic        rready = 1'b0;
   logic        awr, wr, bvo, arr, rv;
   logic [1:0]  bresp, rresp;
   int          fail_count = 0;
   int          compares = 0;

   always #2.5 aclk = ~aclk;

   tom_output #(.TMO_SHORT_P(TMO_W'(TS)), .TMO_LONG_P(TMO_W'(TL)), .HB_PULSE_P(HB_W'(HB)))
   u_tom_output (.aclk(aclk), .aresetn(aresetn), .option_strap_a(strap_a),
      .option_strap_b(strap_b), .gain_high(gain), .burst_valid(burst_v), .burst(burst),
      .sense_out(so), .sense_oe_n(oe_n), .recal_req(recal), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bvo),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rready));

   tom_load u_tom_load (.aclk(aclk), .aresetn(aresetn), .sense_out(so), .sense_oe_n(oe_n),
      .swap_pull(swap), .pin(pin), .pulse_cnt(pcnt));

   task automatic end_of_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic hang();
      fail_count++;
      $display("CHECK FAILED wait expected finish seen timeout");
      end_of_test();
   endtask : hang

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      awaddr <= a;
      wdata  <= d;
      awv    <= 1'b1;
      wv     <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
         if (n > 50) hang();
      end while (bvo !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr <= a;
      arv    <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arv && arr) arv <= 1'b0;
         if (n > 50) hang();
      end while (rv !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd

   function automatic logic [15:0] hit(input logic [15:0] rf, input logic [15:0] dl);
      return rf + dl + 16'h0001 + 16'($urandom % 40);
   endfunction : hit

   task automatic send(input logic [15:0] sig, input logic [15:0] rf);
      int          hi;
      logic [15:0] p0;
      logic        vis;
      hi = 0;
      p0 = pcnt;
      vis = swap | so;
      burst_v <= 1'b1;
      burst   <= '{signal: sig, reference: rf};
      @(posedge aclk);
      burst_v <= 1'b0;
      repeat (GAP)
      begin
         @(posedge aclk);
         hi += int'(oe_n === 1'b1);
      end
      chk("pulse width", HB, hi);
      chk("pulse seen", 32'(p0 + 16'(vis)), 32'(pcnt));
   endtask : send

   task automatic wait_recal(input int lim);
      int n;
      n = GAP;
      while (recal !== 1'b1 && n < 1000)
      begin
         @(posedge aclk);
         n++;
      end
      chk("timeout", 1, (lim > 0) ? (n >= lim && n <= lim + 4) : (n >= 1000));
      repeat (4) @(posedge aclk);
   endtask : wait_recal

   initial
   begin
      logic [31:0] d;
      logic [1:0]  r, em;
      logic [15:0] rf, dl, hy;
      int          nrec;
      d = $urandom(32'h6ccb);
      for (int m = 0; m < 4; m++)
      begin
         em = 2'(m);
         strap_a <= (m < 2);
         strap_b <= (m == 0 || m == 3);
         gain    <= em[0];
         swap    <= em[1];
         aresetn <= 1'b0;
         repeat (3) @(posedge aclk);
         aresetn <= 1'b1;
         repeat (2) @(posedge aclk);
         strap_a <= ~strap_a;
         strap_b <= ~strap_b;
         rf = 16'h0100 + 16'($urandom % 16384);
         dl = em[0] ? 16'h0006 : 16'h000c;
         hy = dl * 16'd17 / 16'd100;
         axi_rd(ADDR_STATUS, d, r);
         chk("mode", {30'h0, em}, {30'h0, d[5:4]});
         chk("gain", em[0], d[6]);
         chk("straps taken", 1, d[7]);
         chk("idle out", 1, so);
         send(hit(rf, dl), rf);
         send(hit(rf, dl), rf);
         send(rf + dl, rf);
         send(hit(rf, dl), rf);
         send(hit(rf, dl), rf);
         chk("no early detect", 1, so);
         send(hit(rf, dl), rf);
         chk("detect out", 0, so);
         if (m != 2)
         begin
            send(rf + dl - hy, rf);
            chk("hysteresis hold", 0, so);
            send(rf + dl - hy - 16'h0001, rf);
            chk("released", 1, so);
            repeat (3) send(hit(rf, dl), rf);
         end
         wait_recal(m == 1 ? TL : (m == 3 ? 0 : TS));
         chk("after timeout", m < 2, so);
         nrec = (m != 3);
         if (m < 2)
         begin
            send(hit(rf, dl), rf);
            chk("stays inactive", 1, so);
         end
         if (m == 2)
         begin
            repeat (3) send(hit(rf, dl), rf);
            chk("toggle back", 1, so);
         end
         axi_wr(ADDR_CONTROL, 32'h1, r);
         chk("ctrl resp", RESP_OKAY, r);
         axi_rd(ADDR_CONTROL, d, r);
         chk("ctrl reads zero", 0, d);
         axi_rd(ADDR_RECAL_CNT, d, r);
         chk("recal count", nrec + 1, d[15:0]);
         axi_rd(4'hc, d, r);
         chk("unmapped resp", RESP_SLVERR, r);
         chk("unmapped data", 0, d);
         if (m == 3)
            chk("sw recal out", 1, so);
         $display("test %0d done", m);
      end
      end_of_test();
   end

   initial
   begin
      repeat (100000) @(posedge aclk);
      hang();
   end
endmodule : test_touch_output_mode_logic

/* File: tom_load.sv */
// Load model on the sense output: pull resistor and pulse counter
`timescale 1ns/1ps
module tom_load
(
   input  wire logic   aclk,
   input  wire logic   aresetn,
   input  wire logic   sense_out,
   input  wire logic   sense_oe_n,
   input  wire logic   swap_pull,
   output logic        pin,
   output logic [15:0] pulse_cnt
);
   logic pull_reg;
   logic pin_d;

   // Released pin settles to the resistor level
   assign pin = sense_oe_n ? pull_reg : sense_out;

   always_ff @(posedge aclk)
   begin
      if (!sense_oe_n)
         pull_reg <= swap_pull ? ~sense_out : 1'b0;
      pin_d <= pin;
      if (!aresetn)
         pulse_cnt <= 16'h0000;
      else if (sense_oe_n && pin != pin_d && pin == pull_reg)
         pulse_cnt <= pulse_cnt + 16'h0001;
   end
endmodule : tom_load

/* File: tom_output.sv */
// Touch output stage: integrator, output modes, timeout, health pulse, AXI4-Lite registers
`timescale 1ns/1ps
module tom_output
   import tom_pkg::*;
#(
   parameter logic [TMO_W-1:0] TMO_SHORT_P = TMO_SHORT_CYC,
   parameter logic [TMO_W-1:0] TMO_LONG_P  = TMO_LONG_CYC,
   parameter logic [HB_W-1:0]  HB_PULSE_P  = HB_PULSE_CYC
)
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        option_strap_a,
   input  wire logic        option_strap_b,
   input  wire logic        gain_high,
   input  wire logic        burst_valid,
   input  wire tom_burst_s  burst,
   output logic             sense_out,
   output logic             sense_oe_n,
   output logic             recal_req,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   tom_mode_e   mode_reg;
   logic        gain_reg;
   logic        taken_reg;
   logic        detect_reg;
   logic [1:0]  integ_reg;
   logic        toggle_reg;
   logic        out_reg;
   logic        oe_n_reg;
   logic        recal_reg;
   logic [15:0] recal_cnt_reg;
   logic        aw_have_reg;
   logic        w_have_reg;
   logic [3:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        tmo_run;
   logic        tmo_expire;
   logic        hb_run;
   logic        hb_expire;

   // Threshold, hysteresis and per-burst decision
   wire [15:0] gain_delta  = gain_reg ? GAIN_HIGH_DELTA : GAIN_LOW_DELTA;
   wire [16:0] thr_level   = {1'b0, burst.reference} + {1'b0, gain_delta};
   wire [16:0] drop_level  = thr_level - {1'b0, tom_hyst(gain_delta)};
   wire        raw_hit     = {1'b0, burst.signal} > thr_level;
   wire        below_drop  = {1'b0, burst.signal} < drop_level;
   wire        is_toggle   = (mode_reg == TOM_TOGGLE_10S);
   wire        is_infinite = (mode_reg == TOM_LEVEL_INF);
   wire        wr_fire     = aw_have_reg && w_have_reg && !bvalid_reg;
   wire        wr_ctrl     = wr_fire && (aw_addr_reg == ADDR_CONTROL) && w_strb_reg[0];
   wire        sw_recal    = wr_ctrl && w_data_reg[CTRL_RECAL_BIT];
   wire        recal_now   = tmo_expire || sw_recal;
   wire        confirm     = taken_reg && burst_valid && !detect_reg && raw_hit
                             && (integ_reg == INTEG_LAST) && !recal_now;
   wire        release_det = burst_valid && detect_reg && below_drop;
   wire [TMO_W-1:0] tmo_limit = (mode_reg == TOM_LEVEL_60S) ? TMO_LONG_P
                                                             : TMO_SHORT_P;
   wire        out_level   = is_toggle ? !toggle_reg : !detect_reg;

   // Power-up strap capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         taken_reg <= 1'b0;
         mode_reg  <= TOM_LEVEL_10S;
         gain_reg  <= 1'b0;
      end
      else if (!taken_reg)
      begin
         taken_reg <= 1'b1;
         mode_reg  <= tom_decode_mode(option_strap_a, option_strap_b);
         gain_reg  <= gain_high;
      end
   end

   // Detection integrator and hysteresis
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         detect_reg <= 1'b0;
         integ_reg  <= 2'h0;
      end
      else if (recal_now)
      begin
         detect_reg <= 1'b0;
         integ_reg  <= 2'h0;
      end
      else if (taken_reg && burst_valid)
      begin
         if (detect_reg)
            detect_reg <= !below_drop;
         else if (!raw_hit)
            integ_reg <= 2'h0;
         else if (confirm)
         begin
            detect_reg <= 1'b1;
            integ_reg  <= 2'h0;
         end
         else
            integ_reg <= integ_reg + 2'h1;
      end
   end

   // Toggle state, output level and recalibration pulse
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         toggle_reg    <= 1'b0;
         out_reg       <= 1'b1;
         oe_n_reg      <= 1'b0;
         recal_reg     <= 1'b0;
         recal_cnt_reg <= 16'h0000;
      end
      else
      begin
         if (confirm && is_toggle)
            toggle_reg <= !toggle_reg;
         out_reg   <= taken_reg ? out_level : 1'b1;
         oe_n_reg  <= hb_run;
         recal_reg <= recal_now;
         if (recal_now)
            recal_cnt_reg <= recal_cnt_reg + 16'h0001;
      end
   end

   // Max on-duration timer
   tom_timer #(.W(TMO_W)) u_tmo
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (confirm && !is_infinite),
      .clear   (release_det || is_infinite || recal_now),
      .limit   (tmo_limit),
      .running (tmo_run),
      .expire  (tmo_expire)
   );

   // Health pulse timer
   tom_timer #(.W(HB_W)) u_hb
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (burst_valid),
      .clear   (1'b0),
      .limit   (HB_PULSE_P),
      .running (hb_run),
      .expire  (hb_expire)
   );

   // AXI4-Lite slave
   wire [31:0] status_word = {22'h000000, integ_reg, taken_reg, gain_reg, mode_reg,
                              toggle_reg, oe_n_reg, out_reg, detect_reg};
   wire        rd_fire     = s_axi_arvalid && !rvalid_reg;
   wire        rd_hit      = (s_axi_araddr == ADDR_STATUS) || (s_axi_araddr == ADDR_CONTROL)
                             || (s_axi_araddr == ADDR_RECAL_CNT);
   wire [31:0] rd_mux      = (s_axi_araddr == ADDR_STATUS)    ? status_word :
                             (s_axi_araddr == ADDR_RECAL_CNT) ? {16'h0000, recal_cnt_reg} :
                             32'h00000000;
   wire        wr_hit      = (aw_addr_reg == ADDR_STATUS) || (aw_addr_reg == ADDR_CONTROL)
                             || (aw_addr_reg == ADDR_RECAL_CNT);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && !aw_have_reg)
         begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_have_reg)
         begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_reg && s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= RESP_OKAY;
      end
      else if (rd_fire)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_mux;
         rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   assign s_axi_awready = !aw_have_reg;
   assign s_axi_wready  = !w_have_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign sense_out     = out_reg;
   assign sense_oe_n    = oe_n_reg;
   assign recal_req     = recal_reg;

   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic [HB_W-1:0] hb_len;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hb_len <= '0;
      else
         hb_len <= oe_n_reg ? hb_len + HB_W'(1) : '0;
   end

   sequence hit_burst_s;
      burst_valid && raw_hit && !detect_reg && !recal_now;
   endsequence

   level_low_a : assert property ((taken_reg && !is_toggle) |=> (out_reg == !$past(detect_reg)))
      else $error("level output does not follow detection");
   inf_no_tmo_a : assert property (is_infinite |-> !tmo_run && !tmo_expire)
      else $error("timeout ran in infinite mode");
   tmo_recal_a : assert property (tmo_expire |=> recal_reg && !detect_reg)
      else $error("timeout did not recalibrate");
   toggle_limit_a : assert property (is_toggle |-> tmo_limit == TMO_SHORT_P)
      else $error("toggle timeout not short");
   toggle_flip_a : assert property ((confirm && is_toggle) |=> toggle_reg != $past(toggle_reg))
      else $error("toggle did not flip");
   toggle_keep_a : assert property ((tmo_expire && is_toggle) |=> $stable(toggle_reg))
      else $error("toggle changed on timeout");
   hb_width_a : assert property ($fell(oe_n_reg) |-> hb_len == HB_PULSE_P)
      else $error("health pulse width wrong");
   strap_hold_a : assert property ($past(taken_reg) |-> $stable(mode_reg) && $stable(gain_reg))
      else $error("strap value changed after capture");
   integ_three_a : assert property ($rose(detect_reg) |-> $past(integ_reg) == INTEG_LAST)
      else $error("detection confirmed early");
   integ_clear_a : assert property ((taken_reg && burst_valid && !detect_reg && !raw_hit)
                                    |=> integ_reg == 2'h0)
      else $error("integrator not cleared on miss");
   hyst_hold_a : assert property ((burst_valid && detect_reg && !below_drop && !recal_now)
                                  |=> detect_reg)
      else $error("detection dropped inside hysteresis");
   thr_seq_a : assert property ((hit_burst_s ##[1:40] hit_burst_s)
                                |=> (integ_reg != 2'h0) || detect_reg)
      else $error("threshold hit not counted by integrator");

endmodule : tom_output

/* File: tom_pkg.sv */
// Constants, types and decoders shared by the touch output-mode logic
package tom_pkg;

   localparam longint unsigned CLK_HZ        = 64'd200_000_000;
   localparam longint unsigned TMO_SHORT_S   = 64'd10;
   localparam longint unsigned TMO_LONG_S    = 64'd60;
   localparam longint unsigned HB_PULSE_US   = 64'd300;
   localparam int              TMO_W         = 34;
   localparam int              HB_W          = 16;
   localparam logic [TMO_W-1:0] TMO_SHORT_CYC = TMO_W'(CLK_HZ * TMO_SHORT_S);
   localparam logic [TMO_W-1:0] TMO_LONG_CYC  = TMO_W'(CLK_HZ * TMO_LONG_S);
   localparam logic [HB_W-1:0]  HB_PULSE_CYC  = HB_W'((CLK_HZ / 64'd1_000_000) * HB_PULSE_US);

   localparam logic [15:0] GAIN_HIGH_DELTA = 16'h0006;
   localparam logic [15:0] GAIN_LOW_DELTA  = 16'h000c;
   localparam logic [15:0] HYST_PCT        = 16'h0011;
   localparam logic [15:0] PCT_DIV         = 16'h0064;
   localparam logic [1:0]  INTEG_LAST      = 2'h2;

   localparam logic [3:0]  ADDR_STATUS     = 4'h0;
   localparam logic [3:0]  ADDR_CONTROL    = 4'h4;
   localparam logic [3:0]  ADDR_RECAL_CNT  = 4'h8;
   localparam int          CTRL_RECAL_BIT  = 0;
   localparam int          ST_DETECT_BIT   = 0;
   localparam int          ST_OUT_BIT      = 1;
   localparam int          ST_HB_BIT       = 2;
   localparam int          ST_TOGGLE_BIT   = 3;
   localparam int          ST_MODE_LSB     = 4;
   localparam int          ST_GAIN_BIT     = 6;
   localparam int          ST_TAKEN_BIT    = 7;
   localparam int          ST_INTEG_LSB    = 8;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef enum logic [1:0]
   {
      TOM_LEVEL_10S  = 2'b00,
      TOM_LEVEL_60S  = 2'b01,
      TOM_TOGGLE_10S = 2'b10,
      TOM_LEVEL_INF  = 2'b11
   } tom_mode_e;

   typedef struct packed
   {
      logic [15:0] signal;
      logic [15:0] reference;
   } tom_burst_s;

   function automatic tom_mode_e tom_decode_mode(input logic strap_a, input logic strap_b);
      tom_mode_e m;
      m = TOM_LEVEL_10S;
      case ({strap_a, strap_b})
         2'b11:   m = TOM_LEVEL_10S;
         2'b10:   m = TOM_LEVEL_60S;
         2'b00:   m = TOM_TOGGLE_10S;
         default: m = TOM_LEVEL_INF;
      endcase
      return m;
   endfunction : tom_decode_mode

   function automatic logic [15:0] tom_hyst(input logic [15:0] delta);
      logic [31:0] p;
      p = 32'(delta) * 32'(HYST_PCT) / 32'(PCT_DIV);
      return p[15:0];
   endfunction : tom_hyst

endpackage : tom_pkg

/* File: tom_timer.sv */
// Cycle timer that runs for a given number of cycles and then pulses
`timescale 1ns/1ps
module tom_timer
   import tom_pkg::*;
#(
   parameter int W = 16
)
(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         start,
   input  wire logic         clear,
   input  wire logic [W-1:0] limit,
   output logic              running,
   output logic              expire
);

   logic [W-1:0] cnt_reg;
   logic         run_reg;
   logic         exp_reg;
   wire          last_cyc = run_reg && (cnt_reg == (limit - W'(1)));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         exp_reg <= 1'b0;
      end
      else
      begin
         exp_reg <= 1'b0;
         if (clear)
         begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
         end
         else if (start)
         begin
            cnt_reg <= '0;
            run_reg <= 1'b1;
         end
         else if (last_cyc)
         begin
            run_reg <= 1'b0;
            exp_reg <= 1'b1;
         end
         else if (run_reg)
            cnt_reg <= cnt_reg + W'(1);
      end
   end

   assign running = run_reg;
   assign expire  = exp_reg;

endmodule : tom_timer
